/* hw/dcg_burst_step.sv */
// Purpose: next register address for a burst word
// Assumes: data registers of port i at base plus i
// Notes: contextual stepping wraps to the lowest configured port
`timescale 1ns/1ns
module dcg_burst_step #(
  parameter int NUM_PORTS = 12
) (
  input wire logic [7:0] addr_in,
  input wire logic write_in,
  input wire logic contextual_in,
  input wire logic [11:0] adc_ports_in,
  input wire logic [11:0] dac_ports_in,
  output logic [7:0] next_addr_out
);
  initial begin
    if (NUM_PORTS != 12) begin
      $error("dcg_burst_step serves twelve ports only");
    end
  end

  wire logic [7:0] adc_off = addr_in - dcg_pkg::ADDR_ADC_DATA_BASE;
  wire logic [7:0] dac_off = addr_in - dcg_pkg::ADDR_DAC_DATA_BASE;
  wire logic in_adc = (addr_in >= dcg_pkg::ADDR_ADC_DATA_BASE) && (adc_off < 8'(NUM_PORTS));
  wire logic in_dac = (addr_in >= dcg_pkg::ADDR_DAC_DATA_BASE) && (dac_off < 8'(NUM_PORTS));
  wire logic adc_ctx = contextual_in && in_adc && !write_in;
  wire logic dac_ctx = contextual_in && in_dac && write_in;
  wire logic [7:0] plain_next = addr_in + dcg_pkg::ADDR_STEP;
  wire logic [11:0] mask = adc_ctx ? adc_ports_in : dac_ports_in;
  wire logic [7:0] offs = adc_ctx ? adc_off : dac_off;
  wire logic [7:0] base = adc_ctx ? dcg_pkg::ADDR_ADC_DATA_BASE : dcg_pkg::ADDR_DAC_DATA_BASE;

  logic [7:0] higher;
  logic [7:0] lowest;
  logic found_higher;
  logic found_any;

  always_comb begin
    higher = 8'h00;
    lowest = 8'h00;
    found_higher = 1'b0;
    found_any = 1'b0;
    for (int i = NUM_PORTS - 1; i >= 0; i--) begin
      if (mask[i]) begin
        lowest = 8'(i);
        found_any = 1'b1;
        if (8'(i) > offs) begin
          higher = 8'(i);
          found_higher = 1'b1;
        end
      end
    end
  end

  // only adc reads and dac writes
  wire logic [7:0] ctx_next = base + (found_higher ? higher : lowest);
  assign next_addr_out = ((adc_ctx || dac_ctx) && found_any) ? ctx_next : plain_next;
endmodule

/* hw/dcg_pkg.sv */
// Purpose: shared constants, map and types for the device control and port data registers
// Assumes: 16-bit registers reached word by word from the serial interface front end
// Notes: 8-bit register addresses
package dcg_pkg;
  localparam int NUM_PORTS = 12;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 16;
  localparam int PRESET_W = 12;
  localparam int TEMP_W = 12;

  // register addresses
  localparam logic [7:0] ADDR_PORT_INPUT = 8'h0b;
  localparam logic [7:0] ADDR_PORT_OUTPUT = 8'h0d;
  localparam logic [7:0] ADDR_CONTROL = 8'h10;
  localparam logic [7:0] ADDR_PRESET_ONE = 8'h16;
  localparam logic [7:0] ADDR_PRESET_TWO = 8'h17;
  localparam logic [7:0] ADDR_TEMP_CFG = 8'h18;
  localparam logic [7:0] ADDR_ADC_DATA_BASE = 8'h40;
  localparam logic [7:0] ADDR_DAC_DATA_BASE = 8'h60;
  localparam logic [7:0] ADDR_STEP = 8'h01;

  // control word fields
  localparam int CTL_DAC_REF = 6;
  localparam int CTL_THERMAL_SHDN = 7;
  localparam int CTL_MON_LO = 8;
  localparam int CTL_MON_HI = 10;
  localparam int CTL_MON_INTERNAL = 8;
  localparam int CTL_CONV_TIME = 11;
  localparam int CTL_SERIES_RESISTANCE_CANCEL = 12;
  localparam int CTL_LOW_POWER = 13;
  localparam int CTL_BURST_MODE = 14;
  localparam int CTL_SOFT_RESET = 15;
  localparam logic [15:0] CTL_STORED_MASK = 16'h7fc0;

  // averaging fields
  localparam int AVG_INT_LO = 0;
  localparam int AVG_EXT1_LO = 2;
  localparam int AVG_EXT2_LO = 4;
  localparam logic [15:0] TEMP_CFG_MASK = 16'h003f;
  localparam logic [5:0] AVG_MIN_SAMPLES = 6'h04;

  // dac update modes that select a preset word
  localparam logic [1:0] DAC_MODE_PRESET_ONE = 2'h2;
  localparam logic [1:0] DAC_MODE_PRESET_TWO = 2'h3;

  // reset values
  localparam logic [15:0] CONTROL_RESET = 16'h0000;
  localparam logic [15:0] OUTPUT_RESET = 16'h0000;
  localparam logic [15:0] PRESET_RESET = 16'h0000;
  localparam logic [15:0] TEMP_CFG_RESET = 16'h0000;

  // thermal trip: degrees and code scale of 0.125 degree per lsb
  localparam int THERMAL_LIMIT_DEG = 145;
  localparam int TEMP_LSB_PER_DEG = 8;
  localparam logic [11:0] THERMAL_LIMIT_CODE = 12'(THERMAL_LIMIT_DEG * TEMP_LSB_PER_DEG);

  typedef struct packed {
    logic [11:0] adc;
    logic [11:0] dac;
    logic [11:0] general_input_port;
    logic [11:0] general_output_port;
  } dcg_port_cfg_t;

  typedef struct packed {
    logic valid;
    logic first;
    logic write;
    logic [7:0] addr;
    logic [15:0] wdata;
  } dcg_access_t;

  // port to register bit placement
  function automatic logic [15:0] dcg_pack(input logic [11:0] p);
    dcg_pack = {p[10:6], 3'h0, p[5:0], 1'h0, p[11]};
  endfunction

  function automatic logic [11:0] dcg_unpack(input logic [15:0] w);
    dcg_unpack = {w[0], w[15:11], w[7:2]};
  endfunction
endpackage

/* hw/dcg_regs.sv */
// Purpose: device control bits 6 to 15, port level data, dac presets, averaging config
// Assumes: access port driven by serial interface logic on clk_in; pins are asynchronous
// Notes: soft and thermal reset restart every register here except the pin synchroniser and reset requests, and pulse device_reset_out
`timescale 1ns/1ns
module dcg_regs #(
  parameter int NUM_PORTS = 12
) (
  input wire logic clk_in,
  input wire logic reset_in,
  input wire dcg_pkg::dcg_access_t access_in,
  input wire dcg_pkg::dcg_port_cfg_t port_cfg_in,
  input wire logic [1:0] dac_update_mode_in,
  input wire logic [11:0] port_pin_level_in,
  input wire logic [11:0] internal_temp_in,
  input wire logic internal_temp_valid_in,
  output logic [15:0] read_data_out,
  output logic read_valid_out,
  output logic [7:0] access_addr_out,
  output logic [7:0] burst_next_addr_out,
  output logic dac_reference_select_out,
  output logic [2:0] temp_monitor_enables_out,
  output logic temp_conversion_time_sel_out,
  output logic series_resistance_cancel_out,
  output logic low_power_enable_out,
  output logic analog_hiz_out,
  output logic power_on_seq_out,
  output logic device_reset_out,
  output logic [11:0] port_drive_level_out,
  output logic [11:0] port_drive_enable_out,
  output logic [11:0] dac_preset_value_out,
  output logic [11:0] dac_preset_ports_out,
  output logic [5:0] internal_temp_samples_out,
  output logic [5:0] first_remote_samples_out,
  output logic [5:0] second_remote_samples_out
);
  initial begin
    if (NUM_PORTS != 12) begin
      $error("dcg_regs serves twelve ports only");
    end
  end

  logic [15:0] device_control_word;
  logic [15:0] port_output_levels;
  logic [15:0] dac_preset_word_one;
  logic [15:0] dac_preset_word_two;
  logic [15:0] temp_averaging_config;
  logic [7:0] burst_ptr;
  logic [11:0] pin_meta;
  logic [11:0] pin_sync;
  logic soft_reset_req;
  logic thermal_reset_req;

  // pin synchroniser
  always_ff @(posedge clk_in) begin
    pin_meta <= port_pin_level_in;
    pin_sync <= pin_meta;
  end

  wire logic local_reset = reset_in || soft_reset_req || thermal_reset_req;

  // access decode
  wire logic [7:0] cur_addr = access_in.first ? access_in.addr : burst_ptr;
  wire logic wr = access_in.valid && access_in.write;
  wire logic rd = access_in.valid && !access_in.write;
  wire logic wr_ctl = wr && (cur_addr == dcg_pkg::ADDR_CONTROL);
  wire logic wr_out = wr && (cur_addr == dcg_pkg::ADDR_PORT_OUTPUT);
  wire logic wr_p1 = wr && (cur_addr == dcg_pkg::ADDR_PRESET_ONE);
  wire logic wr_p2 = wr && (cur_addr == dcg_pkg::ADDR_PRESET_TWO);
  wire logic wr_tcfg = wr && (cur_addr == dcg_pkg::ADDR_TEMP_CFG);
  wire logic [15:0] preset_mask = 16'((1 << dcg_pkg::PRESET_W) - 1);
  wire logic [15:0] port_bit_mask = dcg_pkg::dcg_pack(12'hfff);

  wire logic [15:0] input_word = dcg_pkg::dcg_pack(pin_sync & port_cfg_in.general_input_port);
  wire logic [15:0] next_read_data =
    (cur_addr == dcg_pkg::ADDR_CONTROL) ? device_control_word :
    (cur_addr == dcg_pkg::ADDR_PORT_INPUT) ? input_word :
    (cur_addr == dcg_pkg::ADDR_PORT_OUTPUT) ? port_output_levels :
    (cur_addr == dcg_pkg::ADDR_PRESET_ONE) ? dac_preset_word_one :
    (cur_addr == dcg_pkg::ADDR_PRESET_TWO) ? dac_preset_word_two :
    (cur_addr == dcg_pkg::ADDR_TEMP_CFG) ? temp_averaging_config : 16'h0000;

  wire logic [7:0] step_addr;
  dcg_burst_step #(
    .NUM_PORTS(NUM_PORTS)
  ) u_step (
    .addr_in(cur_addr),
    .write_in(access_in.write),
    .contextual_in(device_control_word[dcg_pkg::CTL_BURST_MODE]),
    .adc_ports_in(port_cfg_in.adc),
    .dac_ports_in(port_cfg_in.dac),
    .next_addr_out(step_addr)
  );

  assign access_addr_out = cur_addr;
  assign burst_next_addr_out = step_addr;

  wire logic thermal_trip = device_control_word[dcg_pkg::CTL_THERMAL_SHDN] &&
    device_control_word[dcg_pkg::CTL_MON_INTERNAL] && internal_temp_valid_in &&
    ($signed(internal_temp_in) > $signed(dcg_pkg::THERMAL_LIMIT_CODE));
  wire logic lp_exit = wr_ctl && device_control_word[dcg_pkg::CTL_LOW_POWER] &&
    !access_in.wdata[dcg_pkg::CTL_LOW_POWER];

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      soft_reset_req <= 1'b0;
      thermal_reset_req <= 1'b0;
    end else begin
      soft_reset_req <= wr_ctl && access_in.wdata[dcg_pkg::CTL_SOFT_RESET];
      thermal_reset_req <= thermal_trip;
    end
  end

  // reset bit never stored, reads zero
  always_ff @(posedge clk_in) begin
    if (local_reset) begin
      device_control_word <= dcg_pkg::CONTROL_RESET;
    end else if (wr_ctl && !access_in.wdata[dcg_pkg::CTL_SOFT_RESET]) begin
      device_control_word <= access_in.wdata & dcg_pkg::CTL_STORED_MASK;
    end
  end

  always_ff @(posedge clk_in) begin
    if (local_reset) begin
      port_output_levels <= dcg_pkg::OUTPUT_RESET;
      dac_preset_word_one <= dcg_pkg::PRESET_RESET;
      dac_preset_word_two <= dcg_pkg::PRESET_RESET;
      temp_averaging_config <= dcg_pkg::TEMP_CFG_RESET;
    end else begin
      if (wr_out) begin
        port_output_levels <= access_in.wdata & port_bit_mask;
      end
      if (wr_p1) begin
        dac_preset_word_one <= access_in.wdata & preset_mask;
      end
      if (wr_p2) begin
        dac_preset_word_two <= access_in.wdata & preset_mask;
      end
      if (wr_tcfg) begin
        temp_averaging_config <= access_in.wdata & dcg_pkg::TEMP_CFG_MASK;
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (local_reset) begin
      burst_ptr <= 8'h00;
      read_valid_out <= 1'b0;
      read_data_out <= 16'h0000;
      power_on_seq_out <= 1'b0;
    end else begin
      read_valid_out <= rd;
      power_on_seq_out <= lp_exit;
      if (access_in.valid) begin
        burst_ptr <= step_addr;
      end
      if (rd) begin
        read_data_out <= next_read_data;
      end
    end
  end

  assign device_reset_out = local_reset;

  // control outputs
  // reference select
  assign dac_reference_select_out = device_control_word[dcg_pkg::CTL_DAC_REF];
  assign temp_monitor_enables_out = device_control_word[dcg_pkg::CTL_MON_HI:dcg_pkg::CTL_MON_LO];
  assign temp_conversion_time_sel_out = device_control_word[dcg_pkg::CTL_CONV_TIME];
  assign series_resistance_cancel_out = device_control_word[dcg_pkg::CTL_SERIES_RESISTANCE_CANCEL];
  assign low_power_enable_out = device_control_word[dcg_pkg::CTL_LOW_POWER];
  assign analog_hiz_out = low_power_enable_out || local_reset;

  wire logic [11:0] out_levels = dcg_pkg::dcg_unpack(port_output_levels);
  assign port_drive_level_out = out_levels & port_cfg_in.general_output_port;
  assign port_drive_enable_out = analog_hiz_out ? 12'h000 : port_cfg_in.general_output_port;

  wire logic preset_active = dac_update_mode_in[1];
  assign dac_preset_value_out = (dac_update_mode_in == dcg_pkg::DAC_MODE_PRESET_TWO) ?
    dac_preset_word_two[11:0] : dac_preset_word_one[11:0];
  assign dac_preset_ports_out = preset_active ? port_cfg_in.dac : 12'h000;

  assign internal_temp_samples_out =
    dcg_pkg::AVG_MIN_SAMPLES << temp_averaging_config[dcg_pkg::AVG_INT_LO +: 2];
  assign first_remote_samples_out =
    dcg_pkg::AVG_MIN_SAMPLES << temp_averaging_config[dcg_pkg::AVG_EXT1_LO +: 2];
  assign second_remote_samples_out =
    dcg_pkg::AVG_MIN_SAMPLES << temp_averaging_config[dcg_pkg::AVG_EXT2_LO +: 2];

  // checks
  sequence soft_write_s;
    wr_ctl && access_in.wdata[dcg_pkg::CTL_SOFT_RESET];
  endsequence
  sequence trip_s;
    thermal_trip;
  endsequence

  soft_reset_clears_a: assert property (@(posedge clk_in) disable iff (reset_in)
    soft_write_s |=> device_reset_out ##1 (device_control_word == dcg_pkg::CONTROL_RESET))
    else $error("soft reset did not restore control word");
  thermal_reset_a: assert property (@(posedge clk_in) disable iff (reset_in)
    trip_s |=> (device_reset_out && analog_hiz_out) ##1 (port_output_levels == 16'h0000))
    else $error("thermal trip did not reset");
  reset_bit_zero_a: assert property (@(posedge clk_in) disable iff (reset_in)
    !device_control_word[dcg_pkg::CTL_SOFT_RESET])
    else $error("soft reset bit stuck");
  low_power_hiz_a: assert property (@(posedge clk_in) disable iff (reset_in)
    low_power_enable_out |-> analog_hiz_out && (port_drive_enable_out == 12'h000))
    else $error("low power left ports driven");
  lp_exit_seq_a: assert property (@(posedge clk_in) disable iff (reset_in)
    lp_exit |=> power_on_seq_out && !low_power_enable_out)
    else $error("low power exit missed power-on sequence");
  unmapped_zero_a: assert property (@(posedge clk_in) disable iff (reset_in)
    (port_output_levels & ~port_bit_mask) == 16'h0000)
    else $error("unmapped output bits stored");
  input_read_a: assert property (@(posedge clk_in) disable iff (reset_in)
    (rd && cur_addr == dcg_pkg::ADDR_PORT_INPUT) |=> read_valid_out &&
    (read_data_out == dcg_pkg::dcg_pack($past(pin_sync) & $past(port_cfg_in.general_input_port))))
    else $error("input level read wrong");
  plain_step_a: assert property (@(posedge clk_in) disable iff (local_reset)
    (access_in.valid && !device_control_word[dcg_pkg::CTL_BURST_MODE]) |=>
    (burst_ptr == $past(cur_addr) + dcg_pkg::ADDR_STEP))
    else $error("burst address not incremented");
  preset_two_a: assert property (@(posedge clk_in) disable iff (reset_in)
    (dac_update_mode_in == dcg_pkg::DAC_MODE_PRESET_TWO) |->
    (dac_preset_value_out == dac_preset_word_two[11:0]) &&
    (dac_preset_ports_out == port_cfg_in.dac))
    else $error("preset two not broadcast");
  avg_map_a: assert property (@(posedge clk_in) disable iff (reset_in)
    (temp_averaging_config[1:0] == 2'h3) |-> (internal_temp_samples_out == 6'h20))
    else $error("averaging code 11 not 32 samples");
endmodule

/* verif/dcg_host_model.sv */
// Purpose: host side of the register access port, one word per call
// Assumes: words taken at posedge clk_in with valid high
// Notes: released fields show inverted garbage, never stale values
`timescale 1ns/1ns
module dcg_host_model (
  input wire logic clk_in,
  input wire logic [15:0] read_data_in,
  input wire logic read_valid_in,
  input wire logic [7:0] burst_next_in,
  input wire logic [7:0] access_addr_in,
  output dcg_pkg::dcg_access_t access_out,
  output logic [15:0] last_read_out,
  output logic [7:0] last_next_out,
  output logic [7:0] last_addr_out
);
  initial access_out = '0;
  task automatic word(input logic first, input logic write, input logic [7:0] addr,
                      input logic [15:0] wdata);
    @(posedge clk_in);
    access_out <= '{valid: 1'b1, first: first, write: write, addr: addr, wdata: wdata};
    #1 last_next_out = burst_next_in;
    last_addr_out = access_addr_in;
    @(posedge clk_in);
    access_out <= {1'b0, ~access_out[25:0]};
    // read answer is registered at the taking edge and stands right after it
    #1 last_read_out = read_valid_in ? read_data_in : 16'hxxxx;
  endtask
endmodule

/* verif/testbench.sv */
// Purpose: self-checking bench for the control, port data, preset and averaging registers
// Assumes: host model drives the access port, bench drives pins and temperature
// Notes: reset and pulse outputs are counted by monitors
`timescale 1ns/1ns
module testbench;
  logic clk_in = 1'b0;
  logic reset_in = 1'b1;
  dcg_pkg::dcg_access_t acc;
  dcg_pkg::dcg_port_cfg_t cfg = '0;
  logic [1:0] mode = 2'h0;
  logic [11:0] pins = 12'h000;
  logic [11:0] temp = 12'h000;
  logic temp_v = 1'b0;
  logic [15:0] rdata;
  logic rvalid, dref, conv, rs, lp, hiz, pseq, drst;
  logic [7:0] aaddr, nxt;
  logic [2:0] mon;
  logic [11:0] dlvl, den, pval, pports;
  logic [5:0] s_int, s_e1, s_e2;
  int n_mismatch = 0;
  int check_count = 0;
  int cycles = 0;
  int n_rst = 0;
  int n_seq = 0;
  always #25 clk_in = ~clk_in;
  dcg_host_model host (.clk_in(clk_in), .read_data_in(rdata), .read_valid_in(rvalid),
    .burst_next_in(nxt), .access_addr_in(aaddr), .access_out(acc), .last_read_out(),
    .last_next_out(), .last_addr_out());
  dcg_regs #(.NUM_PORTS(12)) dut (.clk_in(clk_in), .reset_in(reset_in), .access_in(acc),
    .port_cfg_in(cfg), .dac_update_mode_in(mode), .port_pin_level_in(pins),
    .internal_temp_in(temp), .internal_temp_valid_in(temp_v), .read_data_out(rdata),
    .read_valid_out(rvalid), .access_addr_out(aaddr), .burst_next_addr_out(nxt),
    .dac_reference_select_out(dref), .temp_monitor_enables_out(mon),
    .temp_conversion_time_sel_out(conv), .series_resistance_cancel_out(rs),
    .low_power_enable_out(lp), .analog_hiz_out(hiz), .power_on_seq_out(pseq),
    .device_reset_out(drst), .port_drive_level_out(dlvl), .port_drive_enable_out(den),
    .dac_preset_value_out(pval), .dac_preset_ports_out(pports),
    .internal_temp_samples_out(s_int), .first_remote_samples_out(s_e1),
    .second_remote_samples_out(s_e2));
  always @(posedge clk_in) begin
    cycles <= cycles + 1;
    if (!reset_in && drst === 1'b1) n_rst <= n_rst + 1;
    if (pseq === 1'b1) n_seq <= n_seq + 1;
    if (cycles == 5000) begin
      n_mismatch = n_mismatch + 1;
      close_out();
    end
  end
  task automatic close_out();
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    host.word(1'b1, 1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [15:0] exp);
    host.word(1'b1, 1'b0, a, 16'h0000);
    check(host.last_read_out, exp);
  endtask
  task automatic temp_pulse(input logic [11:0] t);
    @(posedge clk_in);
    temp <= t;
    temp_v <= 1'b1;
    @(posedge clk_in);
    temp_v <= 1'b0;
    repeat (3) @(posedge clk_in);
  endtask
  initial begin
    logic [7:0] addrs [7] = '{8'h00, 8'h0b, 8'h0d, 8'h10, 8'h16, 8'h17, 8'h18};
    repeat (5) @(posedge clk_in);
    reset_in <= 1'b0;
    foreach (addrs[i]) rd(addrs[i], 16'h0000);
    $display("test reset values done");
    for (int b = 6; b <= 14; b++) begin
      wr(dcg_pkg::ADDR_CONTROL, 16'h0001 << b);
      check({8'h00, lp, rs, conv, mon, 1'b0, dref}, 16'h00fd & (16'h0001 << (b - 6)));
      check({15'h0000, dref}, {15'h0000, b == 6});
      check({15'h0000, hiz}, {15'h0000, b == 13});
      rd(dcg_pkg::ADDR_CONTROL, 16'h0001 << b);
    end
    check(n_seq, 1);
    $display("test control bits done");
    @(posedge clk_in);
    cfg <= '{adc: 12'h024, dac: 12'h0c2, general_input_port: 12'hf0f, general_output_port: 12'h0f0};
    pins <= 12'ha5a;
    wr(dcg_pkg::ADDR_PORT_OUTPUT, 16'hffff);
    rd(dcg_pkg::ADDR_PORT_OUTPUT, 16'hf8fd);
    check({4'h0, dlvl}, 16'h00f0);
    check({4'h0, den}, 16'h00f0);
    wr(dcg_pkg::ADDR_PORT_OUTPUT, 16'h0804);
    check({4'h0, dlvl}, 16'h0040);
    rd(dcg_pkg::ADDR_PORT_INPUT, 16'h4029);
    $display("test port data done");
    for (int c = 0; c < 4; c++) begin
      wr(dcg_pkg::ADDR_TEMP_CFG, 16'hffc0 | (c * 16'h0015));
      rd(dcg_pkg::ADDR_TEMP_CFG, c * 16'h0015);
      check({10'h000, s_int}, 16'h0004 << c);
      check({10'h000, s_e1}, 16'h0004 << c);
      check({10'h000, s_e2}, 16'h0004 << c);
    end
    $display("test averaging done");
    wr(dcg_pkg::ADDR_PRESET_ONE, 16'hfabc);
    host.word(1'b1, 1'b1, dcg_pkg::ADDR_PRESET_TWO, 16'h0123);
    rd(dcg_pkg::ADDR_PRESET_ONE, 16'h0abc);
    @(posedge clk_in);
    mode <= 2'h2;
    @(posedge clk_in);
    #1 check({4'h0, pval}, 16'h0abc);
    check({4'h0, pports}, 16'h00c2);
    @(posedge clk_in);
    mode <= 2'h3;
    @(posedge clk_in);
    #1 check({4'h0, pval}, 16'h0123);
    check({4'h0, pports}, 16'h00c2);
    @(posedge clk_in);
    mode <= 2'h1;
    @(posedge clk_in);
    #1 check({4'h0, pports}, 16'h0000);
    $display("test presets done");
    wr(dcg_pkg::ADDR_CONTROL, 16'h0000);
    host.word(1'b1, 1'b1, dcg_pkg::ADDR_PRESET_ONE, 16'h0111);
    check(host.last_next_out, 16'h0017);
    host.word(1'b0, 1'b1, 8'h00, 16'h0222);
    check(host.last_addr_out, 16'h0017);
    rd(dcg_pkg::ADDR_PRESET_TWO, 16'h0222);
    wr(dcg_pkg::ADDR_CONTROL, 16'h4000);
    host.word(1'b1, 1'b0, 8'h42, 16'h0000);
    check(host.last_next_out, 16'h0045);
    host.word(1'b0, 1'b0, 8'h00, 16'h0000);
    check(host.last_addr_out, 16'h0045);
    check(host.last_next_out, 16'h0042);
    host.word(1'b1, 1'b0, 8'h61, 16'h0000);
    check(host.last_next_out, 16'h0062);
    host.word(1'b1, 1'b1, 8'h61, 16'h0000);
    check(host.last_next_out, 16'h0066);
    $display("test burst done");
    wr(dcg_pkg::ADDR_CONTROL, 16'h8000);
    repeat (2) @(posedge clk_in);
    check(n_rst, 1);
    rd(dcg_pkg::ADDR_CONTROL, 16'h0000);
    rd(dcg_pkg::ADDR_PRESET_TWO, 16'h0000);
    wr(dcg_pkg::ADDR_CONTROL, 16'h0080);
    temp_pulse(12'h489);
    wr(dcg_pkg::ADDR_CONTROL, 16'h0180);
    temp_pulse(12'h488);
    check(n_rst, 1);
    temp_pulse(12'h489);
    check(n_rst, 2);
    rd(dcg_pkg::ADDR_CONTROL, 16'h0000);
    $display("test resets done");
    close_out();
  end
endmodule
